// >>> bench/pio_board.sv
// Board model: pads with external drivers behind the block's pins.
// Assumes pad levels settle within one cycle of the block's drive.
`timescale 1ns/10ps
module pio_board
(
   input wire logic [31:0] pin_out_i,
   input wire logic [31:0] pin_oe_i,
   input wire logic [31:0] ext_i,
   output logic [31:0] pin_level_o
);
   // Device wins where it drives; elsewhere the board level shows
   assign pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);
endmodule

// >>> bench/programmable_io_pin_control_bench.sv
// Bench for the programmable pin block: scoreboarded register traffic.
// Assumes the board model closes the loop from pad drive to pad level.
`timescale 1ns/10ps
module programmable_io_pin_control_bench;
   // ****
   // Signals
   // ****
   logic ref_clk_i = 0;
   logic sys_rst_i = 1;
   logic req = 0, we = 0, wide = 0, ack, busy;
   logic [11:0] addr = 0;
   logic [31:0] wdata = 0, fout = 0, foe = 0, ext = 0, rdata, pout, poe, lvl, fsel, r, m, e;
   logic [15:0] cs_o, clk_o, drv_o;
   logic [15:0] v[7];
   logic [32:0] notes[$];
   logic [32:0] nt;
   int num_errors = 0, n_tests = 0, seed = 16543;

   // Free-running clock, 100 ns period
   always #50 ref_clk_i = ~ref_clk_i;

   pio_pin_ctrl i_pio_pin_ctrl (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .cfg_req_i(req),
      .cfg_we_i(we), .cfg_wide_i(wide), .cfg_addr_i(addr), .cfg_wdata_i(wdata),
      .cfg_rdata_o(rdata), .cfg_ack_o(ack), .cfg_busy_o(busy), .pin_in_i(lvl),
      .pin_out_o(pout), .pin_oe_o(poe), .func_out_i(fout), .func_oe_i(foe),
      .func_sel_o(fsel), .cs_func_o(cs_o), .clk_sel_o(clk_o), .drive_str_o(drv_o));
   pio_board i_pio_board (.pin_out_i(pout), .pin_oe_i(poe), .ext_i(ext), .pin_level_o(lvl));

   // ****
   // Tasks
   // ****
   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", s, x, g);
      end
   endtask

   // One access; request drops after the take edge so it is not taken twice
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic wd, input logic [31:0] x);
      int k;
      notes.push_back({~w, x});
      @(posedge ref_clk_i);
      req <= 1'b1;
      we <= w;
      wide <= wd;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk_i);
      req <= 1'b0;
      k = 0;
      #1;
      if (wd)
         chk("busy", 32'h0000_0001, {31'h0000_0000, busy});
      while (ack !== 1'b1 && k < 8)
      begin
         @(posedge ref_clk_i);
         #1;
         k++;
      end
      chk("ack cycles", {31'h0000_0000, wd}, 32'(k));
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      acc(1'b0, a, 32'h0000_0000, 1'b0, x);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      acc(1'b1, a, d, 1'b0, 32'h0000_0000);
   endtask

   task automatic wr2(input logic [11:0] a, input logic [31:0] d);
      wr(a, d);
      wr(a + 12'h002, d >> 16);
   endtask

   // Waits out pad lag and the two-stage synchroniser before reading
   task automatic lvl2(input logic [31:0] x);
      repeat (6) @(posedge ref_clk_i);
      rd(12'hc30, {16'h0000, x[15:0]});
      rd(12'hc32, {16'h0000, x[31:16]});
   endtask

   task automatic fin(input string s);
      $display("test %s done", s);
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Scoreboard: each ack retires the oldest note
   always @(posedge ref_clk_i)
   begin
      if (ack === 1'b1)
      begin
         nt = notes.pop_front();
         if (nt[32])
            chk("read data", nt[31:0], rdata);
      end
   end

   // ****
   // Tests
   // ****
   initial
   begin
      repeat (3) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      for (int a = 0; a < 14; a++)
         rd(12'hc20 + 12'(2 * a), 0);
      chk("fsel", 0, fsel);
      chk("oe", 0, poe);
      fin("reset");
      // Direction first, while every pin is still general purpose
      for (int i = 6; i >= 0; i--)
      begin
         r = $random(seed);
         v[i] = r[15:0];
         wr(12'hc20 + 12'(2 * i), r);
         rd(12'hc20 + 12'(2 * i), {16'h0000, v[i]});
      end
      chk("cs", v[2], cs_o);
      chk("clk", v[3], clk_o);
      chk("drive", v[4], drv_o);
      chk("fsel", {v[1], v[0]}, fsel);
      r = $random(seed);
      acc(1'b1, 12'hc20, r, 1'b1, 0);
      rd(12'hc20, {16'h0000, r[15:0]});
      rd(12'hc22, {16'h0000, r[31:16]});
      acc(1'b0, 12'hc20, 0, 1'b1, r);
      fin("registers");
      acc(1'b1, 12'hc20, 0, 1'b1, 0);
      wr2(12'hc2a, 32'hffff_ffff);
      e = $random(seed);
      wr2(12'hc30, e);
      lvl2(e);
      // Pin 0 always set, so the set assertion is exercised
      m = $random(seed) | 32'h0000_0001;
      e = e | m;
      wr2(12'hc34, m);
      lvl2(e);
      m = $random(seed) | 32'h0000_0001;
      e = e & ~m;
      wr2(12'hc38, m);
      wr2(12'hc34, 32'h0000_0000);
      wr2(12'hc38, 32'h0000_0000);
      lvl2(e);
      e = $random(seed);
      wr2(12'hc30, e);
      lvl2(e);
      chk("oe", 32'hffff_ffff, poe);
      fin("outputs");
      wr2(12'hc2a, 0);
      r = $random(seed);
      @(posedge ref_clk_i);
      ext <= r;
      wr2(12'hc30, ~r);
      wr2(12'hc34, 32'hffff_ffff);
      lvl2(r);
      fin("inputs");
      r = $random(seed);
      @(posedge ref_clk_i);
      foe <= 32'hffff_ffff;
      fout <= r;
      acc(1'b1, 12'hc20, 32'hffff_ffff, 1'b1, 0);
      wr2(12'hc2a, 32'hffff_ffff);
      wr2(12'hc38, r);
      lvl2(r);
      rd(12'hc2a, 0);
      acc(1'b1, 12'hc20, 0, 1'b1, 0);
      lvl2(ext);
      fin("interface");
      repeat (2) @(posedge ref_clk_i);
      chk("notes left", 0, 32'(notes.size()));
      test_done;
   end

   // Watchdog well beyond the expected run length
   initial
   begin
      #(5000 * 100);
      num_errors++;
      test_done;
   end
endmodule

// >>> include/pio_pins_defines.svh
// Offsets, reset values and lane masks of the programmable pin block.
// Assumes 12-bit byte offsets inside the configuration region.
`ifndef PIO_PINS_DEFINES_SVH
`define PIO_PINS_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_FSEL_LO   12'hc20
`define OFS_FSEL_HI   12'hc22
`define OFS_CS_FUNC   12'hc24
`define OFS_CLK_SEL   12'hc26
`define OFS_DRIVE     12'hc28
`define OFS_DIR_LO    12'hc2a
`define OFS_DIR_HI    12'hc2c
`define OFS_LEVEL_LO  12'hc30
`define OFS_LEVEL_HI  12'hc32
`define OFS_SET_LO    12'hc34
`define OFS_SET_HI    12'hc36
`define OFS_CLR_LO    12'hc38
`define OFS_CLR_HI    12'hc3a

// ****************************************
// Reset values and lanes
// ****************************************
`define RST_REG16     16'h0000
`define RST_REG32     32'h0000_0000
`define LANE_LO_MASK  32'h0000_ffff
`define LANE_HI_MASK  32'hffff_0000

`endif

// >>> include/pio_pins_pkg.sv
// Types shared by the programmable pin block.
// Assumes the defines header is compiled alongside.
package pio_pins_pkg;
   // Register access sequencer: a wide select access takes two steps
   typedef enum logic [0:0] {ACC_IDLE, ACC_WIDE_HI} acc_state_e;
endpackage

// >>> logic/pio_pin_ctrl.sv
// Programmable pin control: 32 pins, function select, direction, data, set, clear.
// Assumes pins and the register port are synchronous to ref_clk_i.
`timescale 1ns/10ps
`include "pio_pins_defines.svh"

// Summary of operation
// - Thirteen registers at fixed offsets configure 32 pins in a low and a high group of 16.
// - Function select bits hand each pin over to its shared interface function.
// - A selected interface pin ignores direction, data, set and clear writes but reads its level.
// - A general-purpose input ignores data, set and clear writes and reads its level.
// - On a general-purpose output a 1 written to the clear bit drives the pin low.
// - On a general-purpose output a 1 written to the set bit drives the pin high.
// - On a general-purpose output a data bit written 0 drives low and 1 drives high.
// - Data reads always return the real pin level whatever the pin's mode.
// - Software uses one of data, set or clear per operation, yet every later write still acts.
// - A drive strength register adjusts the memory interface pin drive.
// - After reset all function select bits are 0, so all pins start as inputs.
// - A 32-bit function select access runs as two 16-bit accesses, low group first.
module pio_pin_ctrl
   import pio_pins_pkg::*;
#(
   parameter int PINS = 32
)
(
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic cfg_req_i,
   input wire logic cfg_we_i,
   input wire logic cfg_wide_i,
   input wire logic [11:0] cfg_addr_i,
   input wire logic [31:0] cfg_wdata_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_ack_o,
   output logic cfg_busy_o,
   input wire logic [PINS-1:0] pin_in_i,
   output logic [PINS-1:0] pin_out_o,
   output logic [PINS-1:0] pin_oe_o,
   input wire logic [PINS-1:0] func_out_i,
   input wire logic [PINS-1:0] func_oe_i,
   output logic [PINS-1:0] func_sel_o,
   output logic [15:0] cs_func_o,
   output logic [15:0] clk_sel_o,
   output logic [15:0] drive_str_o
);

   // ****************************************
   // Declarations
   // ****************************************
   acc_state_e acc_r;
   logic [15:0] wide_hi_r;
   logic [31:0] rdata_r;
   logic ack_r;
   logic busy_r;
   logic wide_we_r;
   logic [31:0] fsel_r;
   logic [31:0] dir_r;
   logic [31:0] data_r;
   logic [31:0] sync1_r;
   logic [31:0] sync2_r;
   logic [15:0] cs_func_r;
   logic [15:0] clk_sel_r;
   logic [15:0] drive_r;
   logic [31:0] pin_out_r;
   logic [31:0] pin_oe_r;
   logic take;
   logic wr_en;
   logic rd_en;
   logic [11:0] acc_addr;
   logic [15:0] wr_data;
   logic [31:0] wr_data32;
   logic [31:0] gp_out;
   logic [31:0] dat_we;
   logic [31:0] set_we;
   logic [31:0] clr_we;
   logic [31:0] fsel_nxt;
   logic [31:0] dir_nxt;
   logic [31:0] data_nxt;

   // Lane mask of a write to a low/high register pair
   function automatic logic [31:0] lane_mask(input logic en, input logic [11:0] addr,
                                             input logic [11:0] lo, input logic [11:0] hi);
      logic [31:0] m;
      m = `RST_REG32;
      if (en && addr == lo)
         m = `LANE_LO_MASK;
      else if (en && addr == hi)
         m = `LANE_HI_MASK;
      return m;
   endfunction

   // Read decode; write-only and unmapped offsets read zero
   function automatic logic [15:0] read_reg(input logic [11:0] addr);
      logic [15:0] v;
      v = `RST_REG16;
      unique case (addr)
         `OFS_FSEL_LO: v = fsel_r[15:0];
         `OFS_FSEL_HI: v = fsel_r[31:16];
         `OFS_CS_FUNC: v = cs_func_r;
         `OFS_CLK_SEL: v = clk_sel_r;
         `OFS_DRIVE: v = drive_r;
         `OFS_DIR_LO: v = dir_r[15:0];
         `OFS_DIR_HI: v = dir_r[31:16];
         `OFS_LEVEL_LO: v = sync2_r[15:0];
         `OFS_LEVEL_HI: v = sync2_r[31:16];
         default: v = `RST_REG16;
      endcase
      return v;
   endfunction

   // ****************************************
   // Register access sequencer
   // ****************************************
   // Requests are taken only while not busy
   assign take = cfg_req_i && !busy_r;
   // Second step of a wide write lands on its own, with no new request
   assign wr_en = (take && cfg_we_i) || (acc_r == ACC_WIDE_HI && wide_we_r);
   assign rd_en = take && !cfg_we_i;
   // Second step of a wide access always targets the high select register
   assign acc_addr = (acc_r == ACC_WIDE_HI) ? `OFS_FSEL_HI : cfg_addr_i;
   assign wr_data = (acc_r == ACC_WIDE_HI) ? wide_hi_r : cfg_wdata_i[15:0];
   assign wr_data32 = {wr_data, wr_data};

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         acc_r <= ACC_IDLE;
         busy_r <= 1'b0;
         wide_we_r <= 1'b0;
         wide_hi_r <= `RST_REG16;
      end
      else if (take && cfg_wide_i && cfg_addr_i == `OFS_FSEL_LO)
      begin
         acc_r <= ACC_WIDE_HI;
         busy_r <= 1'b1;
         wide_we_r <= cfg_we_i;
         wide_hi_r <= cfg_wdata_i[31:16];
      end
      else
      begin
         acc_r <= ACC_IDLE;
         busy_r <= 1'b0;
      end
   end

   // Answer: one cycle for a 16-bit access, two for a wide select access
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         ack_r <= 1'b0;
         rdata_r <= `RST_REG32;
      end
      else
      begin
         ack_r <= (take && !(cfg_wide_i && cfg_addr_i == `OFS_FSEL_LO))
                  || acc_r == ACC_WIDE_HI;
         if (rd_en)
            rdata_r <= {16'h0000, read_reg(cfg_addr_i)};
         else if (acc_r == ACC_WIDE_HI && !wide_we_r)
            rdata_r[31:16] <= read_reg(`OFS_FSEL_HI);
      end
   end

   // ****************************************
   // Pin configuration and data
   // ****************************************
   // only general-purpose outputs take data, set and clear
   assign gp_out = ~fsel_r & dir_r;
   assign dat_we = lane_mask(wr_en, acc_addr, `OFS_LEVEL_LO, `OFS_LEVEL_HI) & gp_out;
   assign set_we = lane_mask(wr_en, acc_addr, `OFS_SET_LO, `OFS_SET_HI) & gp_out & wr_data32;
   assign clr_we = lane_mask(wr_en, acc_addr, `OFS_CLR_LO, `OFS_CLR_HI) & gp_out & wr_data32;

   // select writes always land; direction frozen under interface use
   always_comb
   begin
      fsel_nxt = (fsel_r & ~lane_mask(wr_en, acc_addr, `OFS_FSEL_LO, `OFS_FSEL_HI))
                 | (wr_data32 & lane_mask(wr_en, acc_addr, `OFS_FSEL_LO, `OFS_FSEL_HI));
      dir_nxt = dir_r;
      if (lane_mask(wr_en, acc_addr, `OFS_DIR_LO, `OFS_DIR_HI) != `RST_REG32)
         dir_nxt = (dir_r & (fsel_r | ~lane_mask(wr_en, acc_addr, `OFS_DIR_LO, `OFS_DIR_HI)))
                   | (wr_data32 & ~fsel_r & lane_mask(wr_en, acc_addr, `OFS_DIR_LO, `OFS_DIR_HI));
      // every write acts, whichever register it goes to
      // clear drives low, set drives high
      data_nxt = (((data_r & ~dat_we) | (wr_data32 & dat_we)) | set_we) & ~clr_we;
   end

   // all pins start as general-purpose inputs
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         fsel_r <= `RST_REG32;
         dir_r <= `RST_REG32;
         data_r <= `RST_REG32;
      end
      else
      begin
         fsel_r <= fsel_nxt;
         dir_r <= dir_nxt;
         data_r <= data_nxt;
      end
   end

   // chip select function, clock select and drive strength registers
   // drive strength held for the memory pads
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         cs_func_r <= `RST_REG16;
         clk_sel_r <= `RST_REG16;
         drive_r <= `RST_REG16;
      end
      else if (wr_en && acc_r == ACC_IDLE)
      begin
         if (acc_addr == `OFS_CS_FUNC)
            cs_func_r <= wr_data;
         if (acc_addr == `OFS_CLK_SEL)
            clk_sel_r <= wr_data;
         if (acc_addr == `OFS_DRIVE)
            drive_r <= wr_data;
      end
   end

   // two-stage synchroniser; level read always from the pad
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         sync1_r <= `RST_REG32;
         sync2_r <= `RST_REG32;
      end
      else
      begin
         sync1_r <= pin_in_i;
         sync2_r <= sync1_r;
      end
   end

   // pad mux; pad follows registers one cycle later to keep outputs on flops
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         pin_out_r <= `RST_REG32;
         pin_oe_r <= `RST_REG32;
      end
      else
      begin
         pin_out_r <= (fsel_r & func_out_i) | (~fsel_r & data_r);
         pin_oe_r <= (fsel_r & func_oe_i) | (~fsel_r & dir_r);
      end
   end

   assign cfg_rdata_o = rdata_r;
   assign cfg_ack_o = ack_r;
   assign cfg_busy_o = busy_r;
   assign pin_out_o = pin_out_r;
   assign pin_oe_o = pin_oe_r;
   assign func_sel_o = fsel_r;
   assign cs_func_o = cs_func_r;
   assign clk_sel_o = clk_sel_r;
   assign drive_str_o = drive_r;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   logic wr16;
   assign wr16 = take && cfg_we_i && !cfg_wide_i;

   // Checked at the first edge after release, where the disable no longer masks it
   a_fsel_reset: assert property ($fell(sys_rst_i) |-> fsel_r == `RST_REG32
      && dir_r == `RST_REG32 && pin_oe_o == `RST_REG32)
      else $error("select bits not cleared by reset");
   a_set_high: assert property (wr16 && cfg_addr_i == `OFS_SET_LO && cfg_wdata_i[0]
      && gp_out[0] |-> ##2 pin_out_o[0])
      else $error("set did not drive pin high");
   a_clr_low: assert property (wr16 && cfg_addr_i == `OFS_CLR_LO && cfg_wdata_i[0]
      && gp_out[0] |-> ##2 !pin_out_o[0])
      else $error("clear did not drive pin low");
   a_data_write: assert property (wr16 && cfg_addr_i == `OFS_LEVEL_LO && gp_out[3]
      |=> data_r[3] == $past(cfg_wdata_i[3]))
      else $error("data write not applied");
   a_zero_inert: assert property (wr16 && cfg_addr_i == `OFS_SET_HI && !cfg_wdata_i[0]
      |=> data_r[16] == $past(data_r[16]))
      else $error("set bit written zero changed pin");
   a_iface_lock: assert property (wr16 && fsel_r[1] && cfg_addr_i == `OFS_DIR_LO
      |=> $stable(dir_r[1]))
      else $error("direction changed under interface use");
   a_input_lock: assert property (wr16 && !dir_r[2] && cfg_addr_i == `OFS_LEVEL_LO
      |=> $stable(data_r[2]))
      else $error("input pin data changed by write");
   a_level_read: assert property (rd_en && !cfg_wide_i && cfg_addr_i == `OFS_LEVEL_HI
      |=> cfg_ack_o && cfg_rdata_o[15:0] == $past(pin_in_i[31:16], 3))
      else $error("level read not synchronised pin");
   a_wide_order: assert property (take && cfg_we_i && cfg_wide_i && cfg_addr_i == `OFS_FSEL_LO
      |=> cfg_busy_o && !cfg_ack_o && fsel_r[15:0] == $past(cfg_wdata_i[15:0])
      ##1 cfg_ack_o && fsel_r[31:16] == $past(cfg_wdata_i[31:16], 2))
      else $error("wide select access out of order");
   a_pad_mux: assert property (fsel_r[5] && $stable(fsel_r[5]) |=> pin_oe_o[5] == $past(func_oe_i[5]))
      else $error("interface pin not handed over");

   c_wide: cover property (take && cfg_wide_i && cfg_addr_i == `OFS_FSEL_LO ##2 cfg_ack_o);
   c_set: cover property (|set_we);
   c_clr: cover property (|clr_we);
   c_iface: cover property (fsel_r[0] && pin_oe_o[0]);
endmodule
